/* hw/qmrp_pkg.sv */
// Constants, types and decode functions of the quad-mode read-parameter controller
//------------------------------------------------------------------------------
// Overview of operation
// - After that header the device shifts out its 128-bit factory ID, changing data on falling clocks.
// - Opcode C0h is refused in standard serial mode and taken only in quad command mode.
// - In standard serial mode the wrap length comes from burst_wrap_bits of opcode 77h.
// - Power-up or a reset command gives an 8-byte wrap and four dummy clocks.
// - The dummy count set here applies only to 0Bh, EBh and 0Ch reads in quad command mode.
// - dummy_cycle_field 00 gives 4 clocks, 01 gives 6, 10 and 11 give 8.
// - wrap_length_field 00, 01, 10, 11 give 8, 16, 32 and 64 bytes.
// - A 0Ch read acts as a fast read whose address wraps inside the aligned wrap window.
// - Only opcode 38h in standard serial mode enters quad command mode.
// - With quad_enable clear, 38h is ignored and the device stays in standard serial mode.
// - The device is in exactly one mode at a time and starts in standard serial mode.
// - Opcode FFh in quad command mode returns to standard serial mode.
// - Mode changes by 38h and FFh keep the wrap length; a reset command clears it.
//------------------------------------------------------------------------------
package qmrp_pkg;
    localparam logic [7:0] OPC_UID        = 8'h4B;
    localparam logic [7:0] OPC_SET_PARAM  = 8'hC0;
    localparam logic [7:0] OPC_SET_WRAP   = 8'h77;
    localparam logic [7:0] OPC_ENTER_QUAD = 8'h38;
    localparam logic [7:0] OPC_EXIT_QUAD  = 8'hFF;
    localparam logic [7:0] OPC_FAST_READ  = 8'h0B;
    localparam logic [7:0] OPC_QIO_READ   = 8'hEB;
    localparam logic [7:0] OPC_WRAP_READ  = 8'h0C;
    localparam logic [7:0] OPC_RST_EN     = 8'h66;
    localparam logic [7:0] OPC_RST        = 8'h99;
    localparam logic [7:0] NO_DATA_BYTE   = 8'hFF;

    localparam logic [1:0] DUMMY_FIELD_RST = 2'h0;
    localparam logic [1:0] WRAP_FIELD_RST  = 2'h0;
    localparam int         PARAM_DUMMY_LSB = 4;
    localparam int         PARAM_WRAP_LSB  = 0;
    localparam int         WRAP_BITS_LSB   = 5;

    // Phase lengths in serial clocks
    localparam logic [4:0] CLK_OPC_SPI   = 5'h08;
    localparam logic [4:0] CLK_OPC_QUAD  = 5'h02;
    localparam logic [4:0] CLK_ADDR_SPI  = 5'h18;
    localparam logic [4:0] CLK_ADDR_QUAD = 5'h06;
    localparam logic [4:0] CLK_DUMMY_SPI = 5'h08;
    localparam logic [4:0] CLK_DUMMY_QIO = 5'h06;
    localparam logic [4:0] CLK_PARAM_Q   = 5'h02;
    localparam logic [4:0] CLK_WRAP_CMD  = 5'h08;
    localparam logic [4:0] CLK_DUMMY_00  = 5'h04;
    localparam logic [4:0] CLK_DUMMY_01  = 5'h06;
    localparam logic [4:0] CLK_DUMMY_1X  = 5'h08;
    localparam logic [2:0] NIB_LEFT_QUAD = 3'h1;
    localparam logic [2:0] BIT_LEFT_SPI  = 3'h7;

    localparam logic [5:0] WRAP_MASK_8  = 6'h07;
    localparam logic [5:0] WRAP_MASK_16 = 6'h0F;
    localparam logic [5:0] WRAP_MASK_32 = 6'h1F;
    localparam logic [5:0] WRAP_MASK_64 = 6'h3F;

    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int UID_BITS   = 128;

    typedef struct packed {
        logic [1:0] dummy_cycle_field;
        logic [1:0] wrap_length_field;
    } qmrp_param_type;

    typedef enum logic [5:0] {
        ST_OPC   = 6'h01,
        ST_ADDR  = 6'h02,
        ST_DUMMY = 6'h04,
        ST_DATA  = 6'h08,
        ST_PARAM = 6'h10,
        ST_SKIP  = 6'h20
    } qmrp_state_type;

    function automatic logic [4:0] qmrp_dummy_clocks(input logic [1:0] f);
        if (f == 2'h0)
            return CLK_DUMMY_00;
        else if (f == 2'h1)
            return CLK_DUMMY_01;
        else
            return CLK_DUMMY_1X;
    endfunction

    function automatic logic [5:0] qmrp_wrap_mask(input logic [1:0] f);
        if (f == 2'h0)
            return WRAP_MASK_8;
        else if (f == 2'h1)
            return WRAP_MASK_16;
        else if (f == 2'h2)
            return WRAP_MASK_32;
        else
            return WRAP_MASK_64;
    endfunction
endpackage

/* hw/qmrp_ctrl.sv */
// Read-data FIFO and serial command controller of the quad-mode read-parameter block
`timescale 1ns/1ps
`default_nettype none

module qmrp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp_r;
    logic [AW-1:0]    wp_nxt;
    logic [AW-1:0]    rp_r;
    logic [AW-1:0]    rp_nxt;
    logic [AW:0]      cnt_r;
    logic [AW:0]      cnt_nxt;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_r != DEPTH[AW:0]);
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem[rp_r];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb
    begin
        wp_nxt  = push ? wp_r + 1'b1 : wp_r;
        rp_nxt  = pop ? rp_r + 1'b1 : rp_r;
        cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        if (flush)
        begin
            wp_nxt  = '0;
            rp_nxt  = '0;
            cnt_nxt = '0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end
        else
        begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
        if (push)
            mem[wp_r] <= in_data;
    end
endmodule

module qmrp_ctrl #(
    // Arbitrary value, stands in for the factory identifier
    parameter logic [127:0] UNIQUE_ID = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210
) (
    input  wire logic                    clk_sys,
    input  wire logic                    rst,
    input  wire logic                    spi_clk,
    input  wire logic                    spi_cs_n,
    input  wire logic [3:0]              io_in,
    output logic      [3:0]              io_out,
    output logic      [3:0]              io_oe,
    input  wire logic                    quad_enable,
    output logic                         quad_command_mode,
    output qmrp_pkg::qmrp_param_type     read_param,
    output logic      [23:0]             arr_addr,
    output logic                         arr_ready,
    input  wire logic                    arr_valid,
    input  wire logic [7:0]              arr_data
);
    qmrp_pkg::qmrp_state_type state_r;
    qmrp_pkg::qmrp_state_type state_nxt;
    qmrp_pkg::qmrp_param_type param_r;
    qmrp_pkg::qmrp_param_type param_nxt;
    logic [4:0]  cnt_r, cnt_nxt, need_r, need_nxt, dneed_r, dneed_nxt;
    logic [23:0] sh_r, sh_nxt, addr_r, addr_nxt;
    logic [7:0]  byte_r, byte_nxt;
    logic [3:0]  dout_r, dout_nxt, oe_r, oe_nxt, uid_idx_r, uid_idx_nxt;
    logic [2:0]  left_r, left_nxt;
    logic        qpi_r, qpi_nxt, wide_r, wide_nxt, dwide_r, dwide_nxt;
    logic        uid_r, uid_nxt, wrap_r, wrap_nxt, fetch_r, fetch_nxt;
    logic        rst_en_r, rst_en_nxt, sclk_q_r;
    logic        rise, fall, last, opc_done, flush, pop, acc;
    logic [23:0] sh_in;
    logic [7:0]  opc, src, uid_byte, new_byte;
    logic [23:0] wmask;
    logic        fifo_valid;
    logic        fifo_in_ready;
    logic [7:0]  fifo_data;

    assign rise     = spi_clk && !sclk_q_r && !spi_cs_n;
    assign fall     = !spi_clk && sclk_q_r && !spi_cs_n;
    assign sh_in    = wide_r ? {sh_r[19:0], io_in} : {sh_r[22:0], io_in[0]};
    assign last     = rise && (cnt_r == need_r - 5'h01);
    assign opc      = sh_in[7:0];
    assign opc_done = (state_r == qmrp_pkg::ST_OPC) && last;
    assign flush    = spi_cs_n;
    assign acc      = arr_valid && arr_ready;
    assign arr_ready = fetch_r && fifo_in_ready;
    assign uid_byte = UNIQUE_ID[{~uid_idx_r, 3'h0} +: 8];
    assign new_byte = uid_r ? uid_byte : (fifo_valid ? fifo_data : qmrp_pkg::NO_DATA_BYTE);
    assign pop      = fall && (state_r == qmrp_pkg::ST_DATA) && (left_r == 3'h0) && !uid_r;
    assign wmask    = {18'h0, qmrp_pkg::qmrp_wrap_mask(param_r.wrap_length_field)};
    assign src      = (left_r == 3'h0) ? new_byte : byte_r;

    qmrp_fifo #(
        .WIDTH(qmrp_pkg::FIFO_WIDTH),
        .DEPTH(qmrp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .flush    (flush),
        .in_valid (arr_valid && fetch_r),
        .in_ready (fifo_in_ready),
        .in_data  (arr_data),
        .out_valid(fifo_valid),
        .out_ready(pop),
        .out_data (fifo_data)
    );

    //--------------------------------------------------------------------------
    // Command sequencer
    //--------------------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;   param_nxt = param_r;   cnt_nxt = cnt_r;
        need_nxt = need_r;     dneed_nxt = dneed_r;   sh_nxt = sh_r;
        addr_nxt = addr_r;     qpi_nxt = qpi_r;       wide_nxt = wide_r;
        dwide_nxt = dwide_r;   uid_nxt = uid_r;       wrap_nxt = wrap_r;
        fetch_nxt = fetch_r;   rst_en_nxt = rst_en_r; oe_nxt = oe_r;
        byte_nxt = byte_r;     dout_nxt = dout_r;     left_nxt = left_r;
        uid_idx_nxt = uid_idx_r;
        if (spi_cs_n)
        begin
            state_nxt = qmrp_pkg::ST_OPC;
            cnt_nxt   = 5'h00;
            wide_nxt  = qpi_r;
            need_nxt  = qpi_r ? qmrp_pkg::CLK_OPC_QUAD : qmrp_pkg::CLK_OPC_SPI;
            fetch_nxt = 1'b0;
            oe_nxt    = 4'h0;
            left_nxt  = 3'h0;
        end
        else if (rise && (state_r != qmrp_pkg::ST_DATA) && (state_r != qmrp_pkg::ST_SKIP))
        begin
            sh_nxt  = sh_in;
            cnt_nxt = last ? 5'h00 : cnt_r + 5'h01;
            if (last)
            begin
                case (state_r)
                    qmrp_pkg::ST_OPC:
                    begin
                        state_nxt  = qmrp_pkg::ST_SKIP;
                        rst_en_nxt = (opc == qmrp_pkg::OPC_RST_EN);
                        uid_nxt    = 1'b0;
                        wrap_nxt   = 1'b0;
                        if (opc == qmrp_pkg::OPC_UID && !qpi_r)
                        begin
                            state_nxt = qmrp_pkg::ST_ADDR;
                            need_nxt  = qmrp_pkg::CLK_ADDR_SPI;
                            wide_nxt  = 1'b0;
                            dneed_nxt = qmrp_pkg::CLK_DUMMY_SPI;
                            dwide_nxt = 1'b0;
                            uid_nxt   = 1'b1;
                        end
                        else if (opc == qmrp_pkg::OPC_FAST_READ)
                        begin
                            state_nxt = qmrp_pkg::ST_ADDR;
                            need_nxt  = qpi_r ? qmrp_pkg::CLK_ADDR_QUAD : qmrp_pkg::CLK_ADDR_SPI;
                            wide_nxt  = qpi_r;
                            dneed_nxt = qpi_r ? qmrp_pkg::qmrp_dummy_clocks(param_r.dummy_cycle_field)
                                              : qmrp_pkg::CLK_DUMMY_SPI;
                            dwide_nxt = qpi_r;
                        end
                        else if (opc == qmrp_pkg::OPC_QIO_READ || (opc == qmrp_pkg::OPC_WRAP_READ && qpi_r))
                        begin
                            state_nxt = qmrp_pkg::ST_ADDR;
                            need_nxt  = qmrp_pkg::CLK_ADDR_QUAD;
                            wide_nxt  = 1'b1;
                            dneed_nxt = qpi_r ? qmrp_pkg::qmrp_dummy_clocks(param_r.dummy_cycle_field)
                                              : qmrp_pkg::CLK_DUMMY_QIO;
                            dwide_nxt = 1'b1;
                            wrap_nxt  = (opc == qmrp_pkg::OPC_WRAP_READ);
                        end
                        else if ((opc == qmrp_pkg::OPC_SET_PARAM && qpi_r) || (opc == qmrp_pkg::OPC_SET_WRAP && !qpi_r))
                        begin
                            state_nxt = qmrp_pkg::ST_PARAM;
                            need_nxt  = qpi_r ? qmrp_pkg::CLK_PARAM_Q : qmrp_pkg::CLK_WRAP_CMD;
                            wide_nxt  = 1'b1;
                        end
                        else if (opc == qmrp_pkg::OPC_ENTER_QUAD && !qpi_r && quad_enable)
                            qpi_nxt = 1'b1;
                        else if (opc == qmrp_pkg::OPC_EXIT_QUAD && qpi_r)
                            qpi_nxt = 1'b0;
                        else if (opc == qmrp_pkg::OPC_RST && rst_en_r)
                        begin
                            param_nxt.dummy_cycle_field = qmrp_pkg::DUMMY_FIELD_RST;
                            param_nxt.wrap_length_field = qmrp_pkg::WRAP_FIELD_RST;
                            qpi_nxt = 1'b0;
                        end
                    end
                    qmrp_pkg::ST_ADDR:
                    begin
                        state_nxt   = qmrp_pkg::ST_DUMMY;
                        addr_nxt    = sh_in;
                        fetch_nxt   = !uid_r;
                        need_nxt    = dneed_r;
                        uid_idx_nxt = 4'h0;
                    end
                    qmrp_pkg::ST_DUMMY:
                    begin
                        state_nxt = qmrp_pkg::ST_DATA;
                        oe_nxt    = dwide_r ? 4'hF : 4'h2;
                    end
                    qmrp_pkg::ST_PARAM:
                    begin
                        state_nxt = qmrp_pkg::ST_SKIP;
                        if (qpi_r)
                        begin
                            param_nxt.dummy_cycle_field = sh_in[qmrp_pkg::PARAM_DUMMY_LSB +: 2];
                            param_nxt.wrap_length_field = sh_in[qmrp_pkg::PARAM_WRAP_LSB +: 2];
                        end
                        else
                            param_nxt.wrap_length_field = sh_in[qmrp_pkg::WRAP_BITS_LSB +: 2];
                    end
                    default:
                        state_nxt = qmrp_pkg::ST_SKIP;
                endcase
            end
        end
        if (fall && state_r == qmrp_pkg::ST_DATA)
        begin
            dout_nxt = dwide_r ? src[7:4] : {2'h0, src[7], 1'b0};
            byte_nxt = dwide_r ? {src[3:0], 4'h0} : {src[6:0], 1'b0};
            left_nxt = (left_r != 3'h0) ? left_r - 3'h1
                     : (dwide_r ? qmrp_pkg::NIB_LEFT_QUAD : qmrp_pkg::BIT_LEFT_SPI);
            if (left_r == 3'h0 && uid_r)
                uid_idx_nxt = uid_idx_r + 4'h1;
        end
        if (acc)
            addr_nxt = wrap_r ? ((addr_r & ~wmask) | ((addr_r + 24'h000001) & wmask))
                              : addr_r + 24'h000001;
    end

    // single mode bit, serial at reset
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state_r   <= qmrp_pkg::ST_OPC;
            param_r   <= '{qmrp_pkg::DUMMY_FIELD_RST, qmrp_pkg::WRAP_FIELD_RST};
            qpi_r     <= 1'b0;
            cnt_r     <= 5'h00;
            need_r    <= qmrp_pkg::CLK_OPC_SPI;
            dneed_r   <= qmrp_pkg::CLK_DUMMY_SPI;
            sh_r      <= 24'h000000;
            addr_r    <= 24'h000000;
            wide_r    <= 1'b0;
            dwide_r   <= 1'b0;
            uid_r     <= 1'b0;
            wrap_r    <= 1'b0;
            fetch_r   <= 1'b0;
            rst_en_r  <= 1'b0;
            oe_r      <= 4'h0;
            byte_r    <= 8'h00;
            dout_r    <= 4'h0;
            left_r    <= 3'h0;
            uid_idx_r <= 4'h0;
            sclk_q_r  <= 1'b0;
        end
        else
        begin
            state_r   <= state_nxt;
            param_r   <= param_nxt;
            qpi_r     <= qpi_nxt;
            cnt_r     <= cnt_nxt;
            need_r    <= need_nxt;
            dneed_r   <= dneed_nxt;
            sh_r      <= sh_nxt;
            addr_r    <= addr_nxt;
            wide_r    <= wide_nxt;
            dwide_r   <= dwide_nxt;
            uid_r     <= uid_nxt;
            wrap_r    <= wrap_nxt;
            fetch_r   <= fetch_nxt;
            rst_en_r  <= rst_en_nxt;
            oe_r      <= oe_nxt;
            byte_r    <= byte_nxt;
            dout_r    <= dout_nxt;
            left_r    <= left_nxt;
            uid_idx_r <= uid_idx_nxt;
            sclk_q_r  <= spi_clk;
        end
    end

    assign io_out            = dout_r;
    assign io_oe             = oe_r;
    assign quad_command_mode = qpi_r;
    assign read_param        = param_r;
    assign arr_addr          = addr_r;

    //--------------------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------------------
    AST_QUAD_ENTRY: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(qpi_r) |-> $past(opc_done && opc == qmrp_pkg::OPC_ENTER_QUAD && quad_enable))
        else $error("quad mode entered without 38h");
    AST_QE_GATE: assert property (@(posedge clk_sys) disable iff (rst)
        opc_done && opc == qmrp_pkg::OPC_ENTER_QUAD && !quad_enable && !qpi_r |=> !qpi_r [*2])
        else $error("38h taken with quad_enable clear");
    AST_C0_REJECT: assert property (@(posedge clk_sys) disable iff (rst)
        opc_done && opc == qmrp_pkg::OPC_SET_PARAM && !qpi_r |=> state_r == qmrp_pkg::ST_SKIP)
        else $error("C0h accepted in serial mode");
    AST_QUAD_EXIT: assert property (@(posedge clk_sys) disable iff (rst)
        opc_done && opc == qmrp_pkg::OPC_EXIT_QUAD && qpi_r |=> !qpi_r)
        else $error("FFh did not leave quad mode");
    AST_WRAP_KEEP: assert property (@(posedge clk_sys) disable iff (rst)
        qpi_r != $past(qpi_r) && $past(opc) != qmrp_pkg::OPC_RST |-> $stable(param_r.wrap_length_field))
        else $error("wrap length changed on mode switch");
    AST_RST_DEFAULT: assert property (@(posedge clk_sys) disable iff (rst)
        opc_done && opc == qmrp_pkg::OPC_RST && rst_en_r |=> param_r == 4'h0 && !qpi_r)
        else $error("reset command did not restore defaults");
    AST_DUMMY_LEN: assert property (@(posedge clk_sys) disable iff (rst)
        state_r == qmrp_pkg::ST_ADDR && last && qpi_r |=> need_r == qmrp_pkg::qmrp_dummy_clocks(param_r.dummy_cycle_field))
        else $error("quad dummy count mismatch");
    AST_WRAP_WINDOW: assert property (@(posedge clk_sys) disable iff (rst)
        acc && wrap_r |=> (addr_r & ~wmask) == ($past(addr_r) & ~$past(wmask)))
        else $error("wrapped read left its window");
    AST_OE_DATA: assert property (@(posedge clk_sys) disable iff (rst)
        io_oe != 4'h0 |-> state_r == qmrp_pkg::ST_DATA && $past(!spi_cs_n))
        else $error("output driven outside data phase");
endmodule

`default_nettype wire

/* sim/qmrp_host.sv */
// Host controller model driving the serial command link
`timescale 1ns/1ps
`default_nettype none
module qmrp_host (
    input  wire logic       clk_sys,
    input  wire logic [3:0] io_wire,
    output logic            spi_clk,
    output logic            spi_cs_n,
    output logic      [3:0] io_drv,
    output logic      [7:0] rx,
    output logic            rx_tgl
);
    initial {spi_clk, spi_cs_n, io_drv, rx, rx_tgl} = {2'b01, 4'hF, 8'h00, 1'b0};
    // Drive lines, raise clock, sample lines
    task automatic tick(input logic [3:0] v, output logic [3:0] s);
        io_drv = v;
        repeat (3) @(negedge clk_sys);
        spi_clk = 1'b1;
        s = io_wire;
        repeat (3) @(negedge clk_sys);
        spi_clk = 1'b0;
    endtask
    task automatic shift(input logic q, input logic [31:0] v, input int n);
        logic [3:0] s;
        for (int i = 0; i < (q ? n / 4 : n); i++)
            tick(q ? v[n - 1 - 4 * i -: 4] : {3'h7, v[n - 1 - i]}, s);
    endtask
    // Released lines toggle at random
    task automatic dummy(input int n);
        logic [3:0] s;
        repeat (n) tick(4'($urandom), s);
    endtask
    task automatic rd(input logic q);
        logic [3:0] s;
        for (int i = 0; i < (q ? 2 : 8); i++)
        begin
            tick(4'($urandom), s);
            rx = q ? {rx[3:0], s} : {rx[6:0], s[1]};
        end
        rx_tgl = ~rx_tgl;
    endtask
    task automatic open_f();
        spi_cs_n = 1'b0;
        repeat (2) @(negedge clk_sys);
    endtask
    task automatic close_f();
        repeat (2) @(negedge clk_sys);
        spi_cs_n = 1'b1;
        io_drv = 4'hF;
        repeat (3) @(negedge clk_sys);
    endtask
endmodule
`default_nettype wire

/* sim/quad_mode_read_param_ctrl_test.sv */
// Self-checking testbench of the quad-mode read-parameter controller
`timescale 1ns/1ps
`default_nettype none
module quad_mode_read_param_ctrl_test;
    // Arbitrary identifier value
    localparam logic [127:0] UID = 128'hA5C3_1E2D_3C4B_5A69_7887_96A5_B4C3_D2E1;
    logic                     clk_sys = 1'b0;
    logic                     rst = 1'b1;
    logic                     spi_clk, spi_cs_n, quad_enable, arr_ready, arr_valid, qcm, rx_tgl;
    logic [3:0]               io_drv, io_out, io_oe, io_wire;
    logic [7:0]               arr_data, rx;
    logic [23:0]              arr_addr, a;
    logic [1:0]               w;
    qmrp_pkg::qmrp_param_type rp;
    logic [7:0]               exp_q[$];
    int                       miscompares = 0;
    int                       check_count = 0;
    assign io_wire = (io_oe & io_out) | (~io_oe & io_drv);
    initial forever #12.5 clk_sys = ~clk_sys;
    qmrp_ctrl #(.UNIQUE_ID(UID)) uut (.clk_sys(clk_sys), .rst(rst), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
        .io_in(io_wire), .io_out(io_out), .io_oe(io_oe), .quad_enable(quad_enable), .quad_command_mode(qcm),
        .read_param(rp), .arr_addr(arr_addr), .arr_ready(arr_ready), .arr_valid(arr_valid), .arr_data(arr_data));
    qmrp_host host (.clk_sys(clk_sys), .io_wire(io_wire), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
        .io_drv(io_drv), .rx(rx), .rx_tgl(rx_tgl));
    function automatic logic [7:0] dat(input logic [23:0] x);
        return x[7:0] ^ x[15:8] ^ x[23:16] ^ 8'h5A;
    endfunction
    task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e)
        begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cmp4(input string nm, input logic [3:0] e, input logic [3:0] g);
        cmp8(nm, {4'h0, e}, {4'h0, g});
    endtask
    task automatic tally_and_finish();
        if (miscompares == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic cmd(input logic q, input logic [7:0] op);
        host.open_f();
        host.shift(q, {24'h0, op}, 8);
    endtask
    task automatic qread(input logic [7:0] op, input int dc, input int n, input logic [23:0] m);
        a = 24'($urandom);
        cmd(1, op);
        host.shift(1, {8'h0, a}, 24);
        host.dummy(dc);
        for (int i = 0; i < n; i++)
        begin
            exp_q.push_back(dat((a & ~m) | (24'(a + i) & m)));
            host.rd(1);
        end
        cmp4("output enable", 4'hF, io_oe);
        host.close_f();
        cmp4("output enable", 4'h0, io_oe);
        cmp4("fetch ready", 4'h0, {3'h0, arr_ready});
    endtask
    // ----------------------------
    // Array side and read monitor
    // ----------------------------
    always @(negedge clk_sys)
    begin
        arr_valid = ($urandom % 4) != 0;
        arr_data = dat(arr_addr);
    end
    always @(rx_tgl)
        if (!rst)
            cmp8("read byte", exp_q.size() ? exp_q.pop_front() : 8'hxx, rx);
    initial
    begin
        repeat (100000) @(posedge clk_sys);
        miscompares++;
        tally_and_finish();
    end
    // ----------------------------
    // Main sequence
    // ----------------------------
    initial
    begin
        void'($urandom(71480));
        {quad_enable, arr_valid, arr_data} = 10'h000;
        repeat (8) @(negedge clk_sys);
        rst = 1'b0;
        cmp4("mode", 4'h0, {3'h0, qcm});
        cmp4("read param", 4'h0, rp);
        cmd(0, 8'h4B);
        host.shift(0, 32'h0, 24);
        host.dummy(8);
        for (int i = 0; i < 18; i++)
        begin
            exp_q.push_back(UID[127 - 8 * (i % 16) -: 8]);
            host.rd(0);
        end
        cmp4("output enable", 4'h2, io_oe);
        host.close_f();
        cmd(0, 8'hC0);
        host.shift(0, 32'h33, 8);
        host.close_f();
        cmp4("read param", 4'h0, rp);
        w = 2'($urandom);
        cmd(0, 8'h77);
        host.shift(1, {25'h0, w, 5'h0}, 32);
        host.close_f();
        cmp4("read param", {2'h0, w}, rp);
        cmd(0, 8'h38);
        host.close_f();
        cmp4("mode", 4'h0, {3'h0, qcm});
        quad_enable = 1'b1;
        cmd(0, 8'h38);
        host.close_f();
        cmp4("mode", 4'h1, {3'h0, qcm});
        cmp4("read param", {2'h0, w}, rp);
        for (int k = 0; k < 4; k++)
        begin
            cmd(1, 8'hC0);
            host.shift(1, {26'h0, 2'(k), 2'h0, 2'(k)}, 8);
            host.close_f();
            cmp4("read param", {2'(k), 2'(k)}, rp);
            qread(8'h0C, k == 0 ? 4 : (k == 1 ? 6 : 8), (8 << k) + 3, 24'((8 << k) - 1));
        end
        qread(8'h0B, 8, 5, 24'hFFFFFF);
        qread(8'hEB, 8, 5, 24'hFFFFFF);
        cmd(1, 8'hFF);
        host.close_f();
        cmp4("mode", 4'h0, {3'h0, qcm});
        cmp4("wrap field", 4'h3, {2'h0, rp.wrap_length_field});
        cmd(0, 8'h66);
        host.close_f();
        cmd(0, 8'h99);
        host.close_f();
        cmp4("read param", 4'h0, rp);
        cmp4("queue left", 4'h0, 4'(exp_q.size()));
        tally_and_finish();
    end
endmodule
`default_nettype wire
